/* File: flash_guard_pkg.sv */
`default_nettype none
package flash_guard_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int HW_RESET_MIN_NS = 1000; // least low time on a reset pin
	localparam int HW_RESET_CYC = (HW_RESET_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int SW_RESET_US = 30; // recovery after a software reset
	localparam int SW_RESET_CYC = SW_RESET_US * CLK_MHZ;
	localparam int PUW_US = 10; // power-up write delay, plain default
	localparam int PUW_CYC = PUW_US * CLK_MHZ;
	localparam int TIMER_W = 16;
	// ------------------------------------------------------------
	// command codes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [7:0] OP_UNLOCK = 8'h39;
	localparam logic [7:0] OP_LOCK = 8'h36;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
	localparam logic [7:0] OP_RELEASE_PD = 8'hAB;
	// ------------------------------------------------------------
	// frame lengths and lock map
	// ------------------------------------------------------------
	localparam logic [5:0] BITS_OP = 6'h08;
	localparam logic [5:0] BITS_OP_DATA = 6'h10;
	localparam logic [5:0] BITS_OP_ADDR = 6'h28;
	localparam int MID_BLOCKS = 510;
	localparam int EDGE_SECTORS = 32;
	localparam int NUM_LOCKS = MID_BLOCKS + EDGE_SECTORS;
	localparam logic [8:0] TOP_BLOCK = 9'h1FF;
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_SWRST = 2'b01,
		MODE_HWRST = 2'b10
	} dev_mode_e;
endpackage
`default_nettype wire

/* File: timer_if.sv */
`default_nettype none
interface timer_if #(parameter int W = 16);
	logic load;
	logic [W-1:0] count;
	logic busy;
	modport ctl (output load, output count, input busy);
	modport tmr (input load, input count, output busy);
endinterface
`default_nettype wire

/* File: sync2.sv */
`default_nettype none
module sync2 #(parameter int W = 1, parameter logic [W-1:0] INIT = '0) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;
	// ------------------------------------------------------------
	// two stages; only the second stage is ever read
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_r <= INIT;
			dout <= INIT;
		end
		else
		begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule // sync2
`default_nettype wire

/* File: cycle_timer.sv */
`default_nettype none
module cycle_timer #(parameter int W = 16) (
	input wire logic clk,
	input wire logic rst,
	timer_if.tmr t
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	// load wins over the running count so a restart is never lost
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (t.load)
			cnt_nxt = t.count;
		else if (cnt_r != '0)
			cnt_nxt = cnt_r - 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end
	assign t.busy = (cnt_r != '0);
endmodule // cycle_timer
`default_nettype wire

/* File: flash_guard.sv */
`default_nettype none
module flash_guard #(
	parameter int SW_RESET_CYCLES = flash_guard_pkg::SW_RESET_CYC,
	parameter int PUW_CYCLES = flash_guard_pkg::PUW_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic [3:0] io_in_pin,
	input wire logic reset_n_pin,
	input wire logic quad_lines_enable,
	input wire logic pin_reset_sel,
	input wire logic protect_scheme_sel,
	input wire logic status_protect_bit,
	input wire logic status_lock_bit,
	input wire logic qpi_mode,
	input wire logic quad_xfer,
	input wire logic region_bp_protected,
	input wire logic out_bit,
	input wire logic out_active,
	input wire logic op_done,
	output logic so_out,
	output logic so_oe_n,
	output logic write_enable_latch,
	output logic powered_down,
	output logic paused,
	output logic reset_busy,
	output logic array_program_go,
	output logic array_erase_go,
	output logic status_write_go,
	output logic array_abort,
	output logic [31:0] array_addr
);
	// ------------------------------------------------------------
	// pin synchronisers and edges
	// ------------------------------------------------------------
	logic [6:0] pins_s;
	logic cs_s, sclk_s, rstn_s, cs_q, sclk_q;
	logic [3:0] io_s;
	sync2 #(.W(7), .INIT(7'h7D)) u_sync (
		.clk(clk),
		.rst(rst),
		.din({reset_n_pin, io_in_pin, sclk_pin, cs_n_pin}),
		.dout(pins_s)
	);
	assign cs_s = pins_s[0];
	assign sclk_s = pins_s[1];
	assign io_s = pins_s[5:2];
	assign rstn_s = pins_s[6];

	// ------------------------------------------------------------
	// timers
	// ------------------------------------------------------------
	timer_if #(.W(flash_guard_pkg::TIMER_W)) hw_t ();
	timer_if #(.W(flash_guard_pkg::TIMER_W)) sw_t ();
	timer_if #(.W(flash_guard_pkg::TIMER_W)) pu_t ();
	cycle_timer #(.W(flash_guard_pkg::TIMER_W)) u_hw (.clk(clk), .rst(rst), .t(hw_t));
	cycle_timer #(.W(flash_guard_pkg::TIMER_W)) u_sw (.clk(clk), .rst(rst), .t(sw_t));
	cycle_timer #(.W(flash_guard_pkg::TIMER_W)) u_pu (.clk(clk), .rst(rst), .t(pu_t));

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	flash_guard_pkg::dev_mode_e mode_r, mode_nxt;
	logic paused_r, paused_nxt, hw_low_q, boot_r, rst_en_r, rst_en_nxt;
	logic wel_r, wel_nxt, pd_r, pd_nxt;
	logic prog_r, prog_nxt, erase_r, erase_nxt, srw_r, srw_nxt, abort_r, abort_nxt;
	logic so_r, so_nxt, oe_n_r, oe_n_nxt;
	logic [39:0] sh_r, sh_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [31:0] addr_r, addr_nxt;
	logic [flash_guard_pkg::NUM_LOCKS-1:0] lock_r, lock_nxt;
	logic hold_fn, hold_req, hw_low, hw_long, blocked, init, sw_fire;
	logic end_evt, rise, fall, wr_ok, sr_ok, region_prot;
	logic [7:0] opc;
	logic [9:0] lidx;

	// lock index: middle blocks first, then sixteen sectors of each edge block
	function automatic logic [9:0] lock_index(input logic [31:0] a);
		logic [8:0] blk;
		blk = a[24:16];
		if (blk == 9'h000)
			lock_index = 10'(flash_guard_pkg::MID_BLOCKS) + {6'h00, a[15:12]};
		else if (blk == flash_guard_pkg::TOP_BLOCK)
			lock_index = 10'(flash_guard_pkg::MID_BLOCKS) + 10'h010 + {6'h00, a[15:12]};
		else
			lock_index = {1'b0, blk} - 10'h001;
	endfunction

	// ------------------------------------------------------------
	// pin functions, resets and gating terms
	// ------------------------------------------------------------
	always_comb
	begin
		// shared pin is pause only with quad off and pause function chosen
		hold_fn = ~quad_lines_enable & ~pin_reset_sel & ~qpi_mode & ~quad_xfer;
		hold_req = hold_fn & ~io_s[3] & ~cs_s;
		// dedicated pin always counts; shared pin only when reset chosen and quad lines off
		hw_low = ~rstn_s | (~quad_lines_enable & pin_reset_sel & ~io_s[3]);
		hw_long = hw_low & hw_low_q & ~hw_t.busy;
		blocked = hw_low | (mode_r != flash_guard_pkg::MODE_RUN);
		rise = sclk_s & ~sclk_q & ~paused_r;
		fall = ~sclk_s & sclk_q & ~paused_r;
		end_evt = cs_s & ~cs_q & ~blocked;
		opc = (cnt_r == flash_guard_pkg::BITS_OP_ADDR) ? sh_r[39:32] :
			(cnt_r == flash_guard_pkg::BITS_OP_DATA) ? sh_r[15:8] : sh_r[7:0];
		lidx = lock_index(sh_r[31:0]);
		region_prot = protect_scheme_sel ? lock_r[lidx] : region_bp_protected;
		wr_ok = wel_r & ~pu_t.busy;
		// the pin weighs in only when it is not a data line
		sr_ok = ~status_lock_bit &
			(~status_protect_bit | io_s[2] | quad_lines_enable | qpi_mode);
		hw_t.load = hw_low & ~hw_low_q;
		hw_t.count = flash_guard_pkg::TIMER_W'(flash_guard_pkg::HW_RESET_CYC);
		pu_t.load = boot_r;
		pu_t.count = flash_guard_pkg::TIMER_W'(PUW_CYCLES);
	end

	// ------------------------------------------------------------
	// pause and shifter
	// ------------------------------------------------------------
	always_comb
	begin
		// pause level follows the request only while the clock is low
		paused_nxt = cs_s ? 1'b0 : (sclk_s ? paused_r : hold_req);
		sh_nxt = sh_r;
		cnt_nxt = cnt_r;
		if (cs_s | blocked)
		begin
			sh_nxt = '0; // select high drops a half-shifted command
			cnt_nxt = '0;
		end
		else if (rise && cnt_r < flash_guard_pkg::BITS_OP_ADDR)
		begin
			if (qpi_mode)
			begin
				sh_nxt = {sh_r[35:0], io_s};
				cnt_nxt = cnt_r + 6'h04;
			end
			else
			begin
				sh_nxt = {sh_r[38:0], io_s[0]};
				cnt_nxt = cnt_r + 6'h01;
			end
		end
		so_nxt = fall ? out_bit : so_r;
		// output floats while paused, deselected or blocked
		oe_n_nxt = ~(~cs_s & ~paused_nxt & out_active & ~blocked);
	end

	// ------------------------------------------------------------
	// command execution and protection
	// ------------------------------------------------------------
	always_comb
	begin
		wel_nxt = wel_r;
		pd_nxt = pd_r;
		rst_en_nxt = rst_en_r;
		lock_nxt = lock_r;
		prog_nxt = 1'b0;
		erase_nxt = 1'b0;
		srw_nxt = 1'b0;
		sw_fire = 1'b0;
		addr_nxt = addr_r;
		if (op_done)
			wel_nxt = 1'b0;
		if (end_evt && cnt_r != 6'h00)
		begin
			if (pd_r)
			begin
				if (cnt_r == flash_guard_pkg::BITS_OP && opc == flash_guard_pkg::OP_RELEASE_PD)
					pd_nxt = 1'b0;
			end
			else
			begin
				rst_en_nxt = 1'b0;
				case (opc)
					flash_guard_pkg::OP_RESET_ENABLE:
						rst_en_nxt = (cnt_r == flash_guard_pkg::BITS_OP);
					flash_guard_pkg::OP_RESET:
						sw_fire = rst_en_r && cnt_r == flash_guard_pkg::BITS_OP;
					flash_guard_pkg::OP_WRITE_ENABLE:
						if (~pu_t.busy)
							wel_nxt = 1'b1;
					flash_guard_pkg::OP_WRITE_DISABLE:
						wel_nxt = 1'b0;
					flash_guard_pkg::OP_POWER_DOWN:
						pd_nxt = 1'b1;
					flash_guard_pkg::OP_STATUS_WRITE:
						srw_nxt = wr_ok & sr_ok & (cnt_r == flash_guard_pkg::BITS_OP_DATA);
					flash_guard_pkg::OP_UNLOCK:
						if (cnt_r == flash_guard_pkg::BITS_OP_ADDR)
							lock_nxt[lidx] = 1'b0;
					flash_guard_pkg::OP_LOCK:
						if (cnt_r == flash_guard_pkg::BITS_OP_ADDR)
							lock_nxt[lidx] = 1'b1;
					flash_guard_pkg::OP_PROGRAM:
						prog_nxt = wr_ok & ~region_prot & (cnt_r == flash_guard_pkg::BITS_OP_ADDR);
					flash_guard_pkg::OP_SECTOR_ERASE,
					flash_guard_pkg::OP_BLOCK_ERASE:
						erase_nxt = wr_ok & ~region_prot & (cnt_r == flash_guard_pkg::BITS_OP_ADDR);
					default:
						rst_en_nxt = 1'b0;
				endcase
				if (prog_nxt | erase_nxt)
					addr_nxt = sh_r[31:0];
			end
		end
		sw_t.load = sw_fire;
		sw_t.count = flash_guard_pkg::TIMER_W'(SW_RESET_CYCLES);
		// reset mode: hardware first, then software recovery
		mode_nxt = mode_r;
		case (mode_r)
			flash_guard_pkg::MODE_RUN:
				if (hw_long)
					mode_nxt = flash_guard_pkg::MODE_HWRST;
				else if (sw_fire)
					mode_nxt = flash_guard_pkg::MODE_SWRST;
			flash_guard_pkg::MODE_SWRST:
				if (hw_long)
					mode_nxt = flash_guard_pkg::MODE_HWRST;
				else if (~sw_t.busy && ~sw_t.load)
					mode_nxt = flash_guard_pkg::MODE_RUN;
			flash_guard_pkg::MODE_HWRST:
				if (~hw_low)
					mode_nxt = flash_guard_pkg::MODE_RUN;
			default:
				mode_nxt = flash_guard_pkg::MODE_RUN;
		endcase
		abort_nxt = hw_long & (mode_r != flash_guard_pkg::MODE_HWRST);
		init = hw_long | sw_fire;
		if (init)
		begin
			// back to power-on contents; a long hardware pulse overrides all
			wel_nxt = 1'b0;
			pd_nxt = 1'b0;
			rst_en_nxt = 1'b0;
			lock_nxt = '1;
			prog_nxt = 1'b0;
			erase_nxt = 1'b0;
			srw_nxt = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_r <= flash_guard_pkg::MODE_RUN;
			paused_r <= 1'b0;
			cs_q <= 1'b1;
			sclk_q <= 1'b0;
			hw_low_q <= 1'b0;
			boot_r <= 1'b1;
			rst_en_r <= 1'b0;
			wel_r <= 1'b0;
			pd_r <= 1'b0;
			lock_r <= '1;
			sh_r <= '0;
			cnt_r <= '0;
			addr_r <= '0;
			prog_r <= 1'b0;
			erase_r <= 1'b0;
			srw_r <= 1'b0;
			abort_r <= 1'b0;
			so_r <= 1'b0;
			oe_n_r <= 1'b1;
		end
		else
		begin
			mode_r <= mode_nxt;
			paused_r <= paused_nxt;
			cs_q <= cs_s;
			sclk_q <= sclk_s;
			hw_low_q <= hw_low;
			boot_r <= 1'b0;
			rst_en_r <= rst_en_nxt;
			wel_r <= wel_nxt;
			pd_r <= pd_nxt;
			lock_r <= lock_nxt;
			sh_r <= sh_nxt;
			cnt_r <= cnt_nxt;
			addr_r <= addr_nxt;
			prog_r <= prog_nxt;
			erase_r <= erase_nxt;
			srw_r <= srw_nxt;
			abort_r <= abort_nxt;
			so_r <= so_nxt;
			oe_n_r <= oe_n_nxt;
		end
	end

	assign so_out = so_r;
	assign so_oe_n = oe_n_r;
	assign write_enable_latch = wel_r;
	assign powered_down = pd_r;
	assign paused = paused_r;
	assign reset_busy = (mode_r != flash_guard_pkg::MODE_RUN);
	assign array_program_go = prog_r;
	assign array_erase_go = erase_r;
	assign status_write_go = srw_r;
	assign array_abort = abort_r;
	assign array_addr = addr_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_sw_seq;
		(mode_r == flash_guard_pkg::MODE_RUN && ~hw_low && sw_fire)
			##1 (mode_r == flash_guard_pkg::MODE_SWRST);
	endsequence
	AST_PAUSE_FLOATS: assert property (paused_r |-> oe_n_r)
		else $error("output driven while paused");
	AST_QUAD_NO_PAUSE: assert property (quad_lines_enable |=> ~paused_nxt)
		else $error("pause taken with quad lines enabled");
	AST_PAUSE_CLK_LOW: assert property ($rose(paused_r) |-> ~$past(sclk_s))
		else $error("pause started with clock high");
	AST_SELECT_ENDS_PAUSE: assert property (cs_s |=> ~paused_r)
		else $error("pause survived deselect");
	AST_SW_RECOVERY: assert property (s_sw_seq |-> ##1 (reset_busy [*8]))
		else $error("software reset recovery too short");
	AST_WEL_DONE: assert property (op_done && !(end_evt && opc == flash_guard_pkg::OP_WRITE_ENABLE)
		|=> ~wel_r)
		else $error("write latch not cleared on completion");
	AST_PD_ONLY_RELEASE: assert property (pd_r && ~init |=> ~prog_r && ~erase_r && ~srw_r)
		else $error("command obeyed in power-down");
	AST_PUW_NO_WEL: assert property (pu_t.busy && ~wel_r && ~rst |=> ~wel_r)
		else $error("write enable during power-up delay");
	AST_HW_LOCKS_SET: assert property (hw_long |=> &lock_r && ~wel_r && reset_busy)
		else $error("hardware reset did not restore power-on state");
	AST_LOCKED_IGNORED: assert property (prog_nxt |-> wel_r && ~region_prot)
		else $error("program accepted into protected region");
endmodule // flash_guard
`default_nettype wire

/* File: spi_host_model.sv */
`default_nettype none
// ------------------------------------------------------------
// bus controller driving the flash pins
// ------------------------------------------------------------
module spi_host_model (
	input wire logic clk,
	input wire logic qpi,
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 10; // 80 ns link clock at 4 ns system clock
	// idle bus: deselected, clock parked low, pause and protect lines high
	initial
	begin
		cs_n = 1'h1;
		sclk = 1'h0;
		io = 4'hF;
	end
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic hold(input logic v);
		step(1);
		io[3] = v;
	endtask
	task automatic wp(input logic v);
		step(1);
		io[2] = v;
	endtask
	task automatic set_sclk(input logic v);
		step(1);
		sclk = v;
	endtask
	task automatic start_frame();
		step(1);
		cs_n = 1'h0;
	endtask
	// msb first; a whole nibble per rise in four-line instruction mode
	task automatic shift(input logic [39:0] v, input int n);
		while (n > 0)
		begin
			if (qpi)
				io = v[39:36];
			else
				io[0] = v[39];
			v = qpi ? v << 4 : v << 1;
			n = qpi ? n - 4 : n - 1;
			step(HALF);
			sclk = 1'h1;
			step(HALF);
			sclk = 1'h0;
		end
	endtask
	// released lines show the inverse of their last value, not a held copy
	task automatic stop_frame();
		step(HALF);
		cs_n = 1'h1;
		if (qpi)
			io = ~io;
		else
			io[0] = ~io[0];
		step(HALF);
	endtask
	task automatic frame(input logic [39:0] v, input int n);
		start_frame();
		shift(v, n);
		stop_frame();
	endtask
	// clock and data wiggle while paused; select stays low throughout
	task automatic noise();
		repeat (3)
		begin
			io[0] = ~io[0];
			set_sclk(1'h1);
			step(HALF - 1);
			set_sclk(1'h0);
			step(HALF - 1);
		end
	endtask
endmodule // spi_host_model
`default_nettype wire

/* File: test_flash_hold_reset_write_guard.sv */
`default_nettype none
module test_flash_hold_reset_write_guard;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(nm, exp, got) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			n_fail++; \
			$display("Error %s expected %0h seen %0h", nm, exp, got); \
		end \
	end
	logic clk, cs_n, sclk, so_out, so_oe_n, latch, pd, paused, busy;
	logic prog_go, erase_go, sw_go, abort;
	logic rst, reset_n, quad_en, pin_sel, scheme;
	logic stat_prot, stat_lock, qpi, quad_xfer;
	logic region_prot, out_active, op_done, out_bit;
	logic [3:0] io;
	logic [31:0] addr;
	int n_fail = 0;
	int n_checks = 0;
	int n_prog = 0, n_erase = 0, n_sw = 0, n_abort = 0, n_busy = 0;
	int k, b;
	logic [4:0] sw_tab [5] = '{5'h01, 5'h08, 5'h0D, 5'h14, 5'h0B}; // lock,prot,wp,quad,ok
	logic [3:0] hw_tab [3] = '{4'hB, 4'h5, 4'h6}; // dedicated,shared sel,quad,reset
	// ------------------------------------------------------------
	// clock, design and bus controller
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	flash_guard #(.SW_RESET_CYCLES(300), .PUW_CYCLES(300)) flash_guard_i (
		.clk(clk), .rst(rst), .cs_n_pin(cs_n), .sclk_pin(sclk), .io_in_pin(io),
		.reset_n_pin(reset_n), .quad_lines_enable(quad_en), .pin_reset_sel(pin_sel),
		.protect_scheme_sel(scheme), .status_protect_bit(stat_prot),
		.status_lock_bit(stat_lock), .qpi_mode(qpi), .quad_xfer(quad_xfer),
		.region_bp_protected(region_prot), .out_bit(out_bit), .out_active(out_active),
		.op_done(op_done), .so_out(so_out), .so_oe_n(so_oe_n),
		.write_enable_latch(latch), .powered_down(pd), .paused(paused),
		.reset_busy(busy), .array_program_go(prog_go), .array_erase_go(erase_go),
		.status_write_go(sw_go), .array_abort(abort), .array_addr(addr));
	spi_host_model spi_host_model_i (.clk(clk), .qpi(qpi), .cs_n(cs_n), .sclk(sclk), .io(io));
	// one-cycle pulses are counted so that no pulse slips by between checks
	// sampled mid-cycle, away from the edge that launches them
	always @(negedge clk)
	begin
		n_prog += int'(prog_go === 1'h1);
		n_erase += int'(erase_go === 1'h1);
		n_sw += int'(sw_go === 1'h1);
		n_abort += int'(abort === 1'h1);
		n_busy += int'(busy === 1'h1);
	end
	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [31:0] a = 32'h0, input int n = 8);
		spi_host_model_i.frame({op, a}, n);
	endtask
	task automatic wr(input logic [7:0] op, input logic [31:0] a, input int n);
		cmd(flash_guard_pkg::OP_WRITE_ENABLE);
		cmd(op, a, n);
	endtask
	task automatic done_pulse();
		op_done = 1'h1;
		step(1);
		op_done = 1'h0;
		step(2);
	endtask
	// bounded wait for recovery; running out of it ends the run
	task automatic wait_idle();
		int i;
		for (i = 0; i < 400; i++)
		begin
			if (busy === 1'h0)
				break;
			step(1);
		end
		if (i == 400)
		begin
			n_fail++;
			end_of_test();
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rst, reset_n, quad_en, pin_sel, scheme, stat_prot} = 6'h30;
		{stat_lock, qpi, quad_xfer, region_prot, out_active, op_done, out_bit} = 7'h00;
		step(4);
		rst = 1'h0;
		step(3);
		`CHK("latch", 1'h0, latch)
		`CHK("oe_n", 1'h1, so_oe_n)
		`CHK("busy", 1'h0, busy)
		cmd(flash_guard_pkg::OP_WRITE_ENABLE);
		`CHK("latch", 1'h0, latch)
		step(150);
		wr(flash_guard_pkg::OP_PROGRAM, 32'h0003_0000, 40);
		`CHK("prog", 1, n_prog)
		`CHK("addr", 32'h0003_0000, addr)
		done_pulse();
		`CHK("latch", 1'h0, latch)
		cmd(flash_guard_pkg::OP_PROGRAM, 32'h0003_0000, 40);
		`CHK("prog", 1, n_prog)
		region_prot = 1'h1;
		wr(flash_guard_pkg::OP_PROGRAM, 32'h0003_0000, 40);
		`CHK("prog", 1, n_prog)
		scheme = 1'h1;
		wr(flash_guard_pkg::OP_BLOCK_ERASE, 32'h0005_0000, 40);
		`CHK("erase", 0, n_erase)
		cmd(flash_guard_pkg::OP_UNLOCK, 32'h0005_0000, 40);
		wr(flash_guard_pkg::OP_SECTOR_ERASE, 32'h0006_0000, 40);
		`CHK("erase", 0, n_erase)
		wr(flash_guard_pkg::OP_BLOCK_ERASE, 32'h0005_0000, 40);
		`CHK("erase", 1, n_erase)
		done_pulse();
		scheme = 1'h0;
		region_prot = 1'h0;
		// status write gating over lock, protect, pin and quad
		for (k = 0; k < 5; k++)
		begin
			b = n_sw;
			{stat_lock, stat_prot} = sw_tab[k][4:3];
			quad_en = sw_tab[k][1];
			quad_xfer = sw_tab[k][1];
			spi_host_model_i.wp(sw_tab[k][2]);
			wr(flash_guard_pkg::OP_STATUS_WRITE, 32'h0, 16);
			`CHK("status_go", b + sw_tab[k][0], n_sw)
			done_pulse();
		end
		{stat_lock, stat_prot, quad_en, quad_xfer} = 4'h0;
		spi_host_model_i.wp(1'h1);
		cmd(flash_guard_pkg::OP_POWER_DOWN);
		`CHK("pd", 1'h1, pd)
		cmd(flash_guard_pkg::OP_WRITE_ENABLE);
		`CHK("latch", 1'h0, latch)
		cmd(flash_guard_pkg::OP_RELEASE_PD);
		`CHK("pd", 1'h0, pd)
		// software reset: broken sequence, then a real one followed at once by a command
		cmd(flash_guard_pkg::OP_WRITE_ENABLE);
		b = n_busy;
		cmd(flash_guard_pkg::OP_RESET_ENABLE);
		cmd(flash_guard_pkg::OP_WRITE_ENABLE);
		cmd(flash_guard_pkg::OP_RESET);
		`CHK("busy_cnt", b, n_busy)
		`CHK("latch", 1'h1, latch)
		cmd(flash_guard_pkg::OP_RESET_ENABLE);
		cmd(flash_guard_pkg::OP_RESET);
		cmd(flash_guard_pkg::OP_WRITE_ENABLE);
		`CHK("latch", 1'h0, latch)
		wait_idle();
		`CHK("busy_len", 1'h1, (n_busy - b >= 300) && (n_busy - b <= 303))
		quad_en = 1'h1;
		qpi = 1'h1;
		cmd(flash_guard_pkg::OP_WRITE_ENABLE);
		`CHK("latch", 1'h1, latch)
		b = n_busy;
		cmd(flash_guard_pkg::OP_RESET_ENABLE);
		cmd(flash_guard_pkg::OP_RESET);
		wait_idle();
		`CHK("latch", 1'h0, latch)
		`CHK("busy_seen", 1'h1, n_busy > b)
		spi_host_model_i.hold(1'h1);
		spi_host_model_i.wp(1'h1);
		qpi = 1'h0;
		// pause refused with quad enable or a quad transfer
		for (k = 0; k < 2; k++)
		begin
			{quad_en, quad_xfer} = (k == 0) ? 2'h2 : 2'h1;
			spi_host_model_i.start_frame();
			spi_host_model_i.hold(1'h0);
			step(10);
			`CHK("paused", 1'h0, paused)
			spi_host_model_i.hold(1'h1);
			spi_host_model_i.stop_frame();
		end
		{quad_en, quad_xfer} = 2'h0;
		// pause in mid-opcode while the clock is high, garbage while paused
		out_active = 1'h1;
		spi_host_model_i.start_frame();
		spi_host_model_i.shift(40'h0, 3);
		spi_host_model_i.set_sclk(1'h1);
		step(9);
		spi_host_model_i.hold(1'h0);
		step(8);
		`CHK("paused", 1'h0, paused)
		spi_host_model_i.set_sclk(1'h0);
		step(8);
		`CHK("paused", 1'h1, paused)
		`CHK("oe_n", 1'h1, so_oe_n)
		// new output data must not be taken on clock falls while paused
		out_bit = 1'h1;
		spi_host_model_i.noise();
		`CHK("paused", 1'h1, paused)
		`CHK("so_out", 1'h0, so_out)
		spi_host_model_i.hold(1'h1);
		step(8);
		`CHK("paused", 1'h0, paused)
		`CHK("oe_n", 1'h0, so_oe_n)
		spi_host_model_i.shift(40'h60_0000_0000, 4);
		spi_host_model_i.stop_frame();
		`CHK("latch", 1'h1, latch)
		`CHK("so_out", 1'h1, so_out)
		out_active = 1'h0;
		// hardware reset on the dedicated pin and on the shared pin
		for (k = 0; k < 3; k++)
		begin
			{pin_sel, quad_en} = hw_tab[k][2:1];
			cmd(flash_guard_pkg::OP_WRITE_ENABLE);
			b = n_abort;
			reset_n = !hw_tab[k][3];
			spi_host_model_i.hold(hw_tab[k][3]);
			step(300);
			`CHK("abort", b + hw_tab[k][0], n_abort)
			`CHK("busy", hw_tab[k][0], busy)
			cmd(flash_guard_pkg::OP_WRITE_ENABLE);
			`CHK("latch", !hw_tab[k][0], latch)
			reset_n = 1'h1;
			spi_host_model_i.hold(1'h1);
			step(10);
			`CHK("busy", 1'h0, busy)
		end
		end_of_test();
	end
endmodule // test_flash_hold_reset_write_guard
`default_nettype wire
